// File: boot_mem_model.sv
// Memory holding the trap vectors, adjustable answer delay
`timescale 1ns/1ps
`default_nettype none
module boot_mem_model
   import cpu_trap_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic [3:0] delay,
   input wire memReq_type memReq,
   output logic memAck,
   output logic [15:0] memRdata
);
   logic [3:0] waitQ; // Cycles waited in this beat
   logic [1:0] nWr; // Next save slot
   logic [15:0] saved [4]; // Words written, in order
   always_ff @(posedge ref_clk) begin
      memAck <= 1'b0;
      memRdata <= ~memRdata; // Stale data toggles so it is never mistaken for valid
      if (!rst_n) begin
         waitQ <= 4'h0;
         nWr <= 2'h0;
         memRdata <= 16'h0;
      end else if (memReq.req && !memAck) begin
         waitQ <= (waitQ == delay) ? 4'h0 : waitQ + 4'h1;
         memAck <= (waitQ == delay);
         if (waitQ == delay && memReq.we) begin
            saved[nWr] <= memReq.wdata;
            nWr <= nWr + 2'h1;
         end else if (waitQ == delay) begin
            memRdata <= (memReq.addr == 16'hfffc) ? 16'h0300 : 16'h4000;
         end
      end
   end
endmodule : boot_mem_model
`default_nettype wire

// File: cpu_trap_ctrl.sv
// Bootstrap trap sequencer, operand addressing and external commands with Wishbone registers
`timescale 1ns/1ps
`default_nettype none
module cpu_trap_ctrl
   import cpu_trap_pkg::*;
#(
   parameter int ADR_W = 8
)
(
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   // Wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [ADR_W-1:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // Processor pins
   input wire logic bootReq_n,
   input wire logic busHold_n,
   input wire logic coprocessorPresent_n,
   input wire logic instructionEnd,
   input wire logic intReq,
   output logic trapAcknowledge,
   output logic memoryMapEnableFlag,
   // External command pins
   output logic [2:0] addrCode,
   output logic dataBusInput,
   output logic bitIoStrobe,
   // Memory bus master
   output memReq_type memReq,
   input wire logic memAck,
   input wire logic [15:0] memRdata
);

   ////////////////////////////////////////////////////////////////////////////////
   // Declarations

   // Trap sequence states
   typedef enum logic [3:0] {
      T_RUN, T_HOLD_ACK, T_FETCH_WP, T_FETCH_PC, T_SAVE_WP, T_SAVE_PC, T_SAVE_ST, T_LOAD
   } trapState_type;

   trapState_type state_q; // Current trap state
   trapState_type state_d; // Next trap state
   logic [15:0] pc_q; // Program counter
   logic [15:0] wp_q; // Workspace pointer
   logic [15:0] st_q; // Status
   logic [15:0] newWp_q; // Fetched vector workspace
   logic [15:0] newPc_q; // Fetched vector counter
   logic [7:0] eaCfg_q; // Operand fields
   logic [15:0] eaReg_q; // Selected register value
   logic [15:0] eaExt_q; // Following word
   logic [15:0] wr12_q; // Bit-I/O base register
   logic [15:0] wr0_q; // Wide operand high
   logic [15:0] wr1_q; // Wide operand low
   logic [7:0] bitDisp_q; // Bit-I/O displacement
   logic holdActive; // Bus hold or coprocessor present
   logic bootReq; // Request seen this cycle
   logic wbReq; // Valid bus cycle awaiting ack
   logic wbWr; // Write taken this cycle
   logic [ADR_W-1:0] wbOfs; // Word-aligned offset
   logic cmdStart; // External command launch
   logic idleActive; // Idle shown on pins
   eaResult_type eaRes; // Operand addressing result
   logic [11:0] bitAddr; // Selected bit address
   logic [15:0] jumpOfs; // Doubled signed displacement

   // Byte-lane merge of a 16-bit register
   function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] dat,
                                           input logic [3:0] sel);
      merge16 = old;
      if (sel[0]) begin
         merge16[7:0] = dat[7:0];
      end
      if (sel[1]) begin
         merge16[15:8] = dat[15:8];
      end
   endfunction : merge16

   ////////////////////////////////////////////////////////////////////////////////
   // Wishbone slave

   assign wbReq = wb_cyc_i && wb_stb_i && !wb_ack_o;
   assign wbWr = wbReq && wb_we_i;
   assign wbOfs = {wb_adr_i[ADR_W-1:2], 2'b00};

   // Ack one cycle after the request; dropped the cycle after
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         wb_ack_o <= 1'b0;
      end else begin
         wb_ack_o <= wbReq;
      end
   end

   // Read data mux; unmapped offsets read zero but still ack
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         wb_dat_o <= 32'h0;
      end else if (wbReq && !wb_we_i) begin
         case (wbOfs)
            OFS_STATUS: wb_dat_o <= {26'h0, idleActive, memoryMapEnableFlag,
                                     trapAcknowledge, state_q != T_RUN, holdActive, bootReq};
            OFS_PC: wb_dat_o <= {16'h0, pc_q};
            OFS_WP: wb_dat_o <= {16'h0, wp_q};
            OFS_ST: wb_dat_o <= {16'h0, st_q};
            OFS_EA_CFG: wb_dat_o <= {24'h0, eaCfg_q};
            OFS_EA_REG: wb_dat_o <= {16'h0, eaReg_q};
            OFS_EA_EXT: wb_dat_o <= {16'h0, eaExt_q};
            OFS_EA_ADDR: wb_dat_o <= {12'h0, 2'b00, eaRes.needExt, eaRes.isDirect,
                                      eaRes.isDirect ? eaRes.operand : eaRes.effAddr};
            OFS_EA_NEXT: wb_dat_o <= {15'h0, eaRes.regWrite, eaRes.regNext};
            OFS_WR12: wb_dat_o <= {16'h0, wr12_q};
            OFS_BITIO: wb_dat_o <= {20'h0, bitAddr};
            OFS_WR0: wb_dat_o <= {16'h0, wr0_q};
            OFS_WR1: wb_dat_o <= {16'h0, wr1_q};
            OFS_WIDE: wb_dat_o <= {wr0_q, wr1_q};
            default: wb_dat_o <= 32'h0;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Trap request sampling

   assign holdActive = !busHold_n || !coprocessorPresent_n;
   assign bootReq = !bootReq_n;

   // Trap sequencer next state
   always_comb begin
      state_d = state_q;
      case (state_q)
         T_RUN: begin
            if (holdActive && bootReq) begin
               state_d = T_HOLD_ACK;
            end else if (!holdActive && bootReq && instructionEnd) begin
               state_d = T_FETCH_WP;
            end
         end
         T_HOLD_ACK: begin
            // Acknowledge stands until the hold lifts, then the trap proceeds
            if (!holdActive) begin
               state_d = T_FETCH_WP;
            end
         end
         T_FETCH_WP: state_d = memAck ? T_FETCH_PC : T_FETCH_WP;
         T_FETCH_PC: state_d = memAck ? T_SAVE_WP : T_FETCH_PC;
         T_SAVE_WP: state_d = memAck ? T_SAVE_PC : T_SAVE_WP;
         T_SAVE_PC: state_d = memAck ? T_SAVE_ST : T_SAVE_PC;
         T_SAVE_ST: state_d = memAck ? T_LOAD : T_SAVE_ST;
         T_LOAD: state_d = T_RUN;
         default: state_d = T_RUN;
      endcase
   end

   // Trap state register
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         state_q <= T_RUN;
      end else begin
         state_q <= state_d;
      end
   end

   // Acknowledge is high in hold service and throughout the WP fetch
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         trapAcknowledge <= 1'b0;
      end else begin
         trapAcknowledge <= (state_d == T_HOLD_ACK) || (state_d == T_FETCH_WP);
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Memory master for vector fetch and context save

   // Request registered from the next state so address and strobe stand together
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         memReq <= '0;
      end else begin
         memReq <= '0;
         case (state_d)
            T_FETCH_WP: memReq <= '{req: 1'b1, we: 1'b0, addr: BOOT_WP_VEC, wdata: 16'h0};
            T_FETCH_PC: memReq <= '{req: 1'b1, we: 1'b0, addr: BOOT_PC_VEC, wdata: 16'h0};
            T_SAVE_WP: memReq <= '{req: 1'b1, we: 1'b1, addr: newWp_q + SAVE_WP_OFS,
                                   wdata: wp_q};
            T_SAVE_PC: memReq <= '{req: 1'b1, we: 1'b1, addr: newWp_q + SAVE_PC_OFS,
                                   wdata: pc_q};
            T_SAVE_ST: memReq <= '{req: 1'b1, we: 1'b1, addr: newWp_q + SAVE_ST_OFS,
                                   wdata: st_q};
            default: memReq <= '0;
         endcase
         // A just-acked beat drops for a cycle so the partner sees a fresh request
         if (memAck) begin
            memReq <= '0;
         end
      end
   end

   // Capture the fetched vectors
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         newWp_q <= 16'h0;
         newPc_q <= 16'h0;
      end else if (memAck && memReq.req && state_q == T_FETCH_WP) begin
         newWp_q <= memRdata;
      end else if (memAck && memReq.req && state_q == T_FETCH_PC) begin
         newPc_q <= memRdata;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Context registers; the trap load outranks software writes

   // Program counter
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         pc_q <= 16'h0;
      end else if (state_q == T_LOAD) begin
         pc_q <= newPc_q;
      end else if (wbWr && wbOfs == OFS_JUMP) begin
         pc_q <= pc_q + jumpOfs;
      end else if (wbWr && wbOfs == OFS_PC) begin
         pc_q <= merge16(pc_q, wb_dat_i, wb_sel_i);
      end
   end

   // Displacement from the low byte, sign-extended and doubled
   assign jumpOfs = {{7{wb_dat_i[7]}}, wb_dat_i[7:0], 1'b0};

   // Workspace pointer
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         wp_q <= 16'h0;
      end else if (state_q == T_LOAD) begin
         wp_q <= newWp_q;
      end else if (wbWr && wbOfs == OFS_WP) begin
         wp_q <= merge16(wp_q, wb_dat_i, wb_sel_i);
      end
   end

   // Status: low bits cleared on trap entry
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         st_q <= 16'h0;
      end else if (state_q == T_LOAD) begin
         st_q <= st_q & ST_KEEP_MASK;
      end else if (wbWr && wbOfs == OFS_ST) begin
         st_q <= merge16(st_q, wb_dat_i, wb_sel_i);
      end
   end

   // Map enable: set by the trap, set wins over a software clear
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         memoryMapEnableFlag <= 1'b0;
      end else if (state_q == T_LOAD) begin
         memoryMapEnableFlag <= 1'b1;
      end else if (wbWr && wbOfs == OFS_CTRL && wb_sel_i[0] && wb_dat_i[CTRL_MAP_CLR]) begin
         memoryMapEnableFlag <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Operand addressing

   // Operand fields and following word
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         eaCfg_q <= 8'h0;
         eaExt_q <= 16'h0;
      end else begin
         if (wbWr && wbOfs == OFS_EA_CFG && wb_sel_i[0]) begin
            eaCfg_q <= wb_dat_i[7:0];
         end
         if (wbWr && wbOfs == OFS_EA_EXT) begin
            eaExt_q <= merge16(eaExt_q, wb_dat_i, wb_sel_i);
         end
      end
   end

   // Selected register; a step command applies the increment after the address is taken
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         eaReg_q <= 16'h0;
      end else if (wbWr && wbOfs == OFS_EA_REG) begin
         eaReg_q <= merge16(eaReg_q, wb_dat_i, wb_sel_i);
      end else if (wbWr && wbOfs == OFS_CTRL && wb_sel_i[0] && wb_dat_i[CTRL_EA_STEP]
                   && eaRes.regWrite) begin
         eaReg_q <= eaRes.regNext;
      end
   end

   operand_addr_unit u_operand_addr (
      .mode(eaCfg_q[CFG_MODE_LSB +: 2]),
      .regSel(eaCfg_q[CFG_REG_LSB +: 4]),
      .byteOp(eaCfg_q[CFG_BYTE]),
      .immediate(eaCfg_q[CFG_IMM]),
      .regVal(eaReg_q),
      .extWord(eaExt_q),
      .result(eaRes)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // Bit-I/O relative addressing and wide operand registers

   // Base register, displacement and the two halves of the wide operand
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         wr12_q <= 16'h0;
         bitDisp_q <= 8'h0;
         wr0_q <= 16'h0;
         wr1_q <= 16'h0;
      end else if (wbWr) begin
         case (wbOfs)
            OFS_WR12: wr12_q <= merge16(wr12_q, wb_dat_i, wb_sel_i);
            OFS_BITIO: bitDisp_q <= wb_sel_i[0] ? wb_dat_i[7:0] : bitDisp_q;
            OFS_WR0: wr0_q <= merge16(wr0_q, wb_dat_i, wb_sel_i);
            OFS_WR1: wr1_q <= merge16(wr1_q, wb_dat_i, wb_sel_i);
            default: wr12_q <= wr12_q;
         endcase
      end
   end

   // Base sits in bits 12..1 of register 12; the 12-bit sum wraps
   assign bitAddr = wr12_q[12:1] + {{4{bitDisp_q[7]}}, bitDisp_q};

   ////////////////////////////////////////////////////////////////////////////////
   // External commands

   assign cmdStart = wbWr && wbOfs == OFS_CTRL && wb_sel_i[0] && wb_dat_i[CTRL_GO];

   ext_cmd_unit u_ext_cmd (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .start(cmdStart),
      .cmdIdx(wb_dat_i[CTRL_CMD_LSB +: 3]),
      .stopIdle(intReq || bootReq),
      .addrCode(addrCode),
      .dataBusInput(dataBusInput),
      .bitIoStrobe(bitIoStrobe),
      .idleActive(idleActive)
   );

endmodule : cpu_trap_ctrl
`default_nettype wire

// File: cpu_trap_ctrl_checker.sv
// Port checker for the trap block
`timescale 1ns/1ps
`default_nettype none
module cpu_trap_ctrl_checker
   import cpu_trap_pkg::*;
(
   // Clock, reset, bus
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_ack_o,
   // Processor pins
   input wire logic bootReq_n,
   input wire logic busHold_n,
   input wire logic coprocessorPresent_n,
   input wire logic instructionEnd,
   input wire logic intReq,
   input wire logic trapAcknowledge,
   input wire logic memoryMapEnableFlag,
   input wire logic [2:0] addrCode,
   input wire logic dataBusInput,
   input wire logic bitIoStrobe,
   input wire memReq_type memReq,
   input wire logic memAck
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   // No hold and no coprocessor
   wire logic free = busHold_n && coprocessorPresent_n;
   // Idle stays up while nothing ends it
   wire logic stay = !intReq && bootReq_n;
   ////////////////////////////////////////////////////////////////////////
   wb_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
      else $error("ack not single");
   trap_take_a: assert property (!bootReq_n && free && instructionEnd && !trapAcknowledge
      && !memReq.req |=> trapAcknowledge && memReq.req && memReq.addr == BOOT_WP_VEC)
      else $error("trap not taken");
   ack_fetch_a: assert property (memReq.req && !memReq.we && memReq.addr == BOOT_WP_VEC
      |-> trapAcknowledge)
      else $error("ack low in fetch");
   pc_vector_a: assert property (memReq.req && memReq.addr == BOOT_WP_VEC && memAck
      |=> !memReq.req ##1 memReq.req && memReq.addr == BOOT_PC_VEC)
      else $error("no counter fetch");
   map_set_a: assert property (memReq.req && memReq.we && memAck && memReq.addr[3:0] == 4'he
      |-> ##[1:3] memoryMapEnableFlag)
      else $error("map flag not set");
   hold_take_a: assert property (!bootReq_n && !free |=> trapAcknowledge)
      else $error("hold not acked");
   hold_stand_a: assert property (trapAcknowledge && !free |=> trapAcknowledge)
      else $error("ack dropped");
   cmd_code_a: assert property (bitIoStrobe |-> dataBusInput && addrCode inside {3'h7, 3'h6,
      3'h5, 3'h3, 3'h2})
      else $error("bad code");
   strobe_pulse_a: assert property (bitIoStrobe |=> !bitIoStrobe)
      else $error("long strobe");
   idle_repeat_a: assert property (bitIoStrobe && addrCode == CODE_IDLE && stay
      ##1 stay [*7] |=> bitIoStrobe)
      else $error("idle not repeated");
   cover property (trapAcknowledge && !free);
   cover property (memReq.we && memAck);
   cover property (bitIoStrobe && addrCode == CODE_IDLE);
endmodule : cpu_trap_ctrl_checker
bind cpu_trap_ctrl cpu_trap_ctrl_checker chk_i (.*);
`default_nettype wire

// File: cpu_trap_pkg.sv
// Shared constants, types and register map of the trap and operand-address block
package cpu_trap_pkg;

   // Data path and trap vector locations
   localparam int WORD_W = 16;
   localparam logic [15:0] BOOT_WP_VEC = 16'hfffc;
   localparam logic [15:0] BOOT_PC_VEC = 16'hfffe;

   // Save slots in the new workspace (byte offsets of registers 13, 14 and 15)
   localparam logic [15:0] SAVE_WP_OFS = 16'h001a;
   localparam logic [15:0] SAVE_PC_OFS = 16'h001c;
   localparam logic [15:0] SAVE_ST_OFS = 16'h001e;

   // Status bits numbered 7..15 from the top sit in bits 8..0; keep only the top seven
   localparam logic [15:0] ST_KEEP_MASK = 16'hfe00;

   // External command codes, driven as {A0,A1,A2}
   localparam logic [2:0] CODE_REG_LOAD = 3'h7;
   localparam logic [2:0] CODE_CLOCK_OFF = 3'h6;
   localparam logic [2:0] CODE_CLOCK_ON = 3'h5;
   localparam logic [2:0] CODE_EXT_RESET = 3'h3;
   localparam logic [2:0] CODE_IDLE = 3'h2;

   // Software command indices for the external commands
   localparam logic [2:0] CMD_REG_LOAD = 3'h0;
   localparam logic [2:0] CMD_CLOCK_OFF = 3'h1;
   localparam logic [2:0] CMD_CLOCK_ON = 3'h2;
   localparam logic [2:0] CMD_EXT_RESET = 3'h3;
   localparam logic [2:0] CMD_IDLE = 3'h4;

   // Operand mode field values
   localparam logic [1:0] MODE_REG = 2'h0;
   localparam logic [1:0] MODE_IND = 2'h1;
   localparam logic [1:0] MODE_IDX = 2'h2;
   localparam logic [1:0] MODE_AUTO = 2'h3;
   localparam logic [15:0] STEP_BYTE = 16'h0001;
   localparam logic [15:0] STEP_WORD = 16'h0002;

   // Idle repetition period of the strobe
   localparam int IDLE_PERIOD_NS = 64;
   localparam int CLK_PERIOD_NS = 8;
   localparam int IDLE_CYCLES = IDLE_PERIOD_NS / CLK_PERIOD_NS;

   // Register byte offsets
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_STATUS = 8'h04;
   localparam logic [7:0] OFS_PC = 8'h08;
   localparam logic [7:0] OFS_WP = 8'h0c;
   localparam logic [7:0] OFS_ST = 8'h10;
   localparam logic [7:0] OFS_EA_CFG = 8'h14;
   localparam logic [7:0] OFS_EA_REG = 8'h18;
   localparam logic [7:0] OFS_EA_EXT = 8'h1c;
   localparam logic [7:0] OFS_EA_ADDR = 8'h20;
   localparam logic [7:0] OFS_EA_NEXT = 8'h24;
   localparam logic [7:0] OFS_JUMP = 8'h28;
   localparam logic [7:0] OFS_WR12 = 8'h2c;
   localparam logic [7:0] OFS_BITIO = 8'h30;
   localparam logic [7:0] OFS_WR0 = 8'h34;
   localparam logic [7:0] OFS_WR1 = 8'h38;
   localparam logic [7:0] OFS_WIDE = 8'h3c;

   // Field positions
   localparam int CTRL_GO = 0;
   localparam int CTRL_CMD_LSB = 1;
   localparam int CTRL_MAP_CLR = 4;
   localparam int CTRL_EA_STEP = 5;
   localparam int CFG_MODE_LSB = 0;
   localparam int CFG_REG_LSB = 2;
   localparam int CFG_BYTE = 6;
   localparam int CFG_IMM = 7;

   // Memory request toward the external bus
   typedef struct packed {
      logic req;
      logic we;
      logic [15:0] addr;
      logic [15:0] wdata;
   } memReq_type;

   // Operand address result
   typedef struct packed {
      logic [15:0] effAddr;
      logic [15:0] operand;
      logic [15:0] regNext;
      logic regWrite;
      logic needExt;
      logic isDirect;
   } eaResult_type;

endpackage : cpu_trap_pkg

// File: ext_cmd_unit.sv
// External-command sequencer: address code, input indication and strobe
`timescale 1ns/1ps
`default_nettype none
module ext_cmd_unit
   import cpu_trap_pkg::*;
(
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   // Command start
   input wire logic start,
   input wire logic [2:0] cmdIdx,
   // Idle terminators
   input wire logic stopIdle,
   // Pins
   output logic [2:0] addrCode,
   output logic dataBusInput,
   output logic bitIoStrobe,
   output logic idleActive
);

   logic [7:0] gapCnt_q; // Cycles until next idle strobe
   logic [2:0] code;

   // Command index to address code
   always_comb begin
      case (cmdIdx)
         CMD_REG_LOAD: code = CODE_REG_LOAD;
         CMD_CLOCK_OFF: code = CODE_CLOCK_OFF;
         CMD_CLOCK_ON: code = CODE_CLOCK_ON;
         CMD_EXT_RESET: code = CODE_EXT_RESET;
         default: code = CODE_IDLE;
      endcase
   end

   // Code and input indication stand while a command or idle is shown
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         addrCode <= 3'h0;
         dataBusInput <= 1'b0;
      end else if (start && cmdIdx <= CMD_IDLE) begin
         addrCode <= code;
         dataBusInput <= 1'b1;
      end else if (!idleActive || stopIdle) begin
         addrCode <= 3'h0;
         dataBusInput <= 1'b0;
      end
   end

   // Idle stays until an interrupt, reset or bootstrap request
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         idleActive <= 1'b0;
      end else if (stopIdle) begin
         idleActive <= 1'b0;
      end else if (start && cmdIdx == CMD_IDLE) begin
         idleActive <= 1'b1;
      end
   end

   // One strobe per command; idle repeats it every IDLE_CYCLES
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         bitIoStrobe <= 1'b0;
         gapCnt_q <= 8'h0;
      end else if (start && cmdIdx <= CMD_IDLE) begin
         bitIoStrobe <= 1'b1;
         gapCnt_q <= 8'(IDLE_CYCLES - 1);
      end else if (idleActive && !stopIdle && gapCnt_q == 8'h0) begin
         bitIoStrobe <= 1'b1;
         gapCnt_q <= 8'(IDLE_CYCLES - 1);
      end else begin
         bitIoStrobe <= 1'b0;
         gapCnt_q <= (gapCnt_q == 8'h0) ? 8'h0 : gapCnt_q - 8'h01;
      end
   end

endmodule : ext_cmd_unit
`default_nettype wire

// File: operand_addr_unit.sv
// Combinational operand effective-address generator
`timescale 1ns/1ps
`default_nettype none
module operand_addr_unit
   import cpu_trap_pkg::*;
(
   // Decoded operand fields
   input wire logic [1:0] mode,
   input wire logic [3:0] regSel,
   input wire logic byteOp,
   input wire logic immediate,
   // Register and instruction-stream words
   input wire logic [15:0] regVal,
   input wire logic [15:0] extWord,
   // Result
   output eaResult_type result
);

   // Step size follows operand width
   logic [15:0] step;
   assign step = byteOp ? STEP_BYTE : STEP_WORD;

   // Mode decode
   always_comb begin
      result = '0;
      result.regNext = regVal;
      if (immediate) begin
         // Operand is the following word itself
         result.operand = extWord;
         result.needExt = 1'b1;
         result.isDirect = 1'b1;
      end else begin
         case (mode)
            MODE_REG: begin
               result.operand = regVal;
               result.isDirect = 1'b1;
            end
            MODE_IND: begin
               result.effAddr = regVal;
            end
            MODE_AUTO: begin
               // Address is the old value; the register advances afterwards
               result.effAddr = regVal;
               result.regNext = regVal + step;
               result.regWrite = 1'b1;
            end
            MODE_IDX: begin
               result.needExt = 1'b1;
               // Register zero never indexes
               if (regSel == 4'h0) begin
                  result.effAddr = extWord;
               end else begin
                  result.effAddr = extWord + regVal;
               end
            end
            default: begin
               result.effAddr = regVal;
            end
         endcase
      end
   end

endmodule : operand_addr_unit
`default_nettype wire

// File: tb_cpu_trap_and_operand_addressing.sv
// Self-checking bench for the trap block
`timescale 1ns/1ps
`default_nettype none
module tb_cpu_trap_and_operand_addressing
   import cpu_trap_pkg::*;
;
   logic ref_clk = 0, rst_n = 0, wb_cyc_i = 0, wb_we_i = 0, intReq = 0, instructionEnd = 0;
   logic bootReq_n = 1, busHold_n = 1, coprocessorPresent_n = 1;
   logic [7:0] wb_adr_i = 0;
   logic [31:0] wb_dat_i = 0, wb_dat_o, q;
   logic wb_ack_o, trapAcknowledge, memoryMapEnableFlag, dataBusInput, bitIoStrobe, memAck;
   logic [2:0] addrCode, lastCode;
   logic [15:0] memRdata;
   logic [3:0] delay = 0;
   memReq_type memReq;
   int n_fail = 0, checks = 0, nStrobe = 0, ticks = 0;
   typedef struct packed {logic [7:0] cfg; logic [15:0] rv, ext; logic [17:0] ea;
      logic [16:0] nx;} row_type;
   row_type rows [7] = '{'{8'h14, 16'h1234, '0, 18'h1234, '0},
      '{8'h15, 16'h1234, '0, 18'h1234, '0}, '{8'h17, 16'h1234, '0, 18'h1234,
      17'h11236}, '{8'h57, 16'h1234, '0, 18'h1234, 17'h11235}, '{8'h02, 16'h1234,
      16'h4000, 18'h24000, '0}, '{8'h0e, 16'h1234, 16'h4000, 18'h25234, '0},
      '{8'h80, 16'h1234, 16'h4000, 18'h24000, '0}};
   logic [2:0] codes [5] = '{3'h7, 3'h6, 3'h5, 3'h3, 3'h2};
   cpu_trap_ctrl dut (.*, .wb_stb_i(wb_cyc_i), .wb_sel_i(4'hf));
   boot_mem_model mem (.*);
   initial forever #4 ref_clk = ~ref_clk;
   // Strobe monitor and hang guard
   always @(posedge ref_clk) begin
      ticks++;
      if (bitIoStrobe) begin
         nStrobe++;
         lastCode = addrCode;
      end
      if (ticks == 20000) begin
         n_fail++;
         give_verdict();
      end
   end
   task automatic chk(input string n, input logic [47:0] s, input logic [47:0] e);
      checks++;
      if (s !== e) begin
         n_fail++;
         $display("mismatch %s expected %h seen %h", n, e, s);
      end
   endtask : chk
   // Classic single cycle; waits for ack
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      {wb_cyc_i, wb_we_i, wb_adr_i, wb_dat_i} <= {1'b1, w, a, d};
      do @(posedge ref_clk); while (wb_ack_o !== 1'b1);
      q = wb_dat_o;
      wb_cyc_i <= 1'b0;
   endtask : wb
   // Requester holds request until ack with vector read
   task automatic boot_wait();
      do @(posedge ref_clk); while (!(trapAcknowledge && memReq.addr == 16'hfffc));
      bootReq_n <= 1'b1;
      do @(posedge ref_clk); while (memoryMapEnableFlag !== 1'b1);
   endtask : boot_wait
   task automatic give_verdict();
      if (n_fail == 0 && checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : give_verdict
   initial begin
      repeat (20) @(posedge ref_clk);
      rst_n <= 1'b1;
      chk("resetOut", {trapAcknowledge, memoryMapEnableFlag, addrCode}, 0);
      foreach (rows[i]) begin
         wb(1, OFS_EA_CFG, rows[i].cfg);
         wb(1, OFS_EA_REG, rows[i].rv);
         wb(1, OFS_EA_EXT, rows[i].ext);
         wb(0, OFS_EA_ADDR, 0);
         chk("eaAddr", q & 32'h2ffff, rows[i].ea);
         wb(0, OFS_EA_NEXT, 0);
         chk("eaNext", q & (rows[i].cfg[1:0] == 2'h3 ? 32'h1ffff : 32'h10000), rows[i].nx);
      end
      wb(1, OFS_WR0, 16'haaaa);
      wb(1, OFS_WR1, 16'h5555);
      wb(0, OFS_WIDE, 0);
      chk("wide", q, 32'haaaa5555);
      wb(1, OFS_PC, 16'h1000);
      wb(1, OFS_JUMP, 8'h80);
      wb(0, OFS_PC, 0);
      chk("pcBack", q, 32'h0f00);
      wb(1, OFS_JUMP, 8'h7f);
      wb(0, OFS_PC, 0);
      chk("pcFwd", q, 32'h0ffe);
      wb(1, OFS_WR12, 16'h0200);
      wb(1, OFS_BITIO, 8'hfe);
      wb(0, OFS_BITIO, 0);
      chk("bitAddr", q, 32'h00fe);
      wb(0, 8'h40, 0);
      chk("unmapped", q, 0);
      nStrobe = 0;
      for (int i = 0; i < 5; i++) begin
         if (i == 4) nStrobe = 0;
         wb(1, OFS_CTRL, {i[2:0], 1'b1});
         repeat (36) @(posedge ref_clk);
         chk("cmdCode", lastCode, codes[i]);
         chk("strobes", nStrobe, (i == 4) ? 5 : i + 1);
      end
      intReq <= 1'b1;
      repeat (2) @(posedge ref_clk);
      nStrobe = 0;
      repeat (20) @(posedge ref_clk);
      chk("idleEnd", nStrobe, 0);
      intReq <= 1'b0;
      wb(1, OFS_PC, 16'h2000);
      wb(1, OFS_WP, 16'h0500);
      wb(1, OFS_ST, 16'hffff);
      {bootReq_n, instructionEnd} <= 2'b01;
      @(posedge ref_clk);
      instructionEnd <= 1'b0;
      boot_wait();
      wb(0, OFS_PC, 0);
      chk("newPc", q, 32'h4000);
      wb(0, OFS_WP, 0);
      chk("newWp", q, 32'h0300);
      wb(0, OFS_ST, 0);
      chk("status", q, 32'hfe00);
      chk("saves", {mem.saved[0], mem.saved[1], mem.saved[2]}, 48'h05002000ffff);
      delay <= 4'h3;
      wb(1, OFS_CTRL, 32'h10);
      {busHold_n, bootReq_n} <= 2'b00;
      repeat (12) @(posedge ref_clk);
      chk("holdAck", trapAcknowledge, 1);
      busHold_n <= 1'b1;
      boot_wait();
      chk("mapFlag", memoryMapEnableFlag, 1);
      give_verdict();
   end
endmodule : tb_cpu_trap_and_operand_addressing
`default_nettype wire
